// ---- design/zsm_param_setup.sv ----
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
// Summary of operation
// - idle 20 s or power loss discards edit
// - standstill monitoring keeps running during setup
// - 3 s hold enters threshold setup, red
// - 6 s hold enters delay setup, green
// - on release show stored level
// - short press steps to next level
// - 2 s hold stores level, leaves setup
// - fifteen threshold levels, on/off values
// - threshold defaults to 80 mV level
// - wait switch-on delay before closing path
// - fifteen delay levels, 0.5 to 20 s
// - movement opens path, output, lamp off
// - delay running flashes lamp; default 1 s
// - delay done: lamp green, path, output on
// - open circuit clears, resume automatically
// - error flashes power lamp red
module zsm_param_setup #(
  parameter int unsigned ENTER_THR_CYC = zsm_pkg::CYC_ENTER_THR,
  parameter int unsigned ENTER_DLY_CYC = zsm_pkg::CYC_ENTER_DLY,
  parameter int unsigned SAVE_CYC      = zsm_pkg::CYC_SAVE,
  parameter int unsigned IDLE_CYC      = zsm_pkg::CYC_IDLE,
  parameter int unsigned HALF_SEC_CYC  = zsm_pkg::CYC_HALF_SEC,
  parameter int unsigned FLASH_CYC     = zsm_pkg::CYC_FLASH
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             set_button,
  input  wire logic             below_on_thr,
  input  wire logic             above_off_thr,
  input  wire logic             open_circuit,
  input  wire logic             internal_error,
  input  wire zsm_pkg::levels_s nv_levels,
  output zsm_pkg::levels_s      active_levels,
  output logic                  nv_store,
  output logic      [9:0]       on_thr_mv,
  output logic      [9:0]       off_thr_mv,
  output logic                  enable_path,
  output logic                  motion_signal_out,
  output logic                  fault_signal_out,
  output zsm_pkg::lamp_s        power_indicator,
  output zsm_pkg::lamp_s        standstill_lamp,
  output zsm_pkg::lamp_s        level_lamp_low,
  output zsm_pkg::lamp_s        level_lamp_high
);

  function automatic logic [3:0] fix_level(input logic [3:0] l, input logic [3:0] d);
    fix_level = (l == 4'h0) ? d : l;
  endfunction

  function automatic logic [3:0] next_level(input logic [3:0] l);
    next_level = (l == zsm_pkg::LEVEL_MAX) ? zsm_pkg::LEVEL_MIN : 4'(l + 4'h1);
  endfunction

  function automatic logic [9:0] thr_on_mv(input logic [3:0] l);
    case (l)
      4'h1:    thr_on_mv = 10'h032;
      4'h2:    thr_on_mv = 10'h037;
      4'h3:    thr_on_mv = 10'h03C;
      4'h4:    thr_on_mv = 10'h041;
      4'h5:    thr_on_mv = 10'h046;
      4'h6:    thr_on_mv = 10'h04B;
      4'h7:    thr_on_mv = 10'h050;
      4'h8:    thr_on_mv = 10'h0C8;
      4'h9:    thr_on_mv = 10'h0E6;
      4'hA:    thr_on_mv = 10'h0FA;
      4'hB:    thr_on_mv = 10'h12C;
      4'hC:    thr_on_mv = 10'h15E;
      4'hD:    thr_on_mv = 10'h190;
      4'hE:    thr_on_mv = 10'h1CC;
      default: thr_on_mv = 10'h1F4;
    endcase
  endfunction

  // delay in half seconds; 0.5 s steps keep the 0.5 s level exact
  function automatic logic [31:0] delay_cycles(input logic [3:0] l);
    logic [5:0] half;
    half = 6'h00;
    case (l)
      4'h1:    half = 6'h01;
      4'h2:    half = 6'h02;
      4'h3:    half = 6'h04;
      4'h4:    half = 6'h06;
      4'h5:    half = 6'h08;
      4'h6:    half = 6'h0A;
      4'h7:    half = 6'h0C;
      4'h8:    half = 6'h0E;
      4'h9:    half = 6'h10;
      4'hA:    half = 6'h14;
      4'hB:    half = 6'h18;
      4'hC:    half = 6'h1C;
      4'hD:    half = 6'h20;
      4'hE:    half = 6'h24;
      default: half = 6'h28;
    endcase
    delay_cycles = 32'(32'(half) * HALF_SEC_CYC);
  endfunction

  zsm_pkg::levels_s stored_r;
  logic             loaded_r;
  logic             lock_r;
  zsm_pkg::setup_e  st_r;
  logic             mode_dly_r;
  logic [3:0]       edit_r;
  logic [31:0]      hold_cnt_r;
  logic [31:0]      idle_cnt_r;
  zsm_pkg::mon_e    mon_r;
  logic [31:0]      dly_cnt_r;
  logic [31:0]      flash_cnt_r;
  logic             flash_r;
  logic             int_err_r;
  logic             pressed;
  logic             save;
  logic             fault_any;
  logic             apb_access;
  logic             apb_done_wr;
  logic             mapped;
  logic [31:0]      status_word;

  assign pressed     = set_button & ~lock_r;
  assign save        = (st_r == zsm_pkg::SET_EDIT_PRESS) && pressed && (hold_cnt_r >= SAVE_CYC - 1);
  assign fault_any   = open_circuit | internal_error | int_err_r;
  assign apb_access  = psel & penable & ~pready;
  assign apb_done_wr = psel & penable & pready & pwrite;
  assign mapped      = (paddr == zsm_pkg::ADDR_CTRL) || (paddr == zsm_pkg::ADDR_STATUS) ||
                       (paddr == zsm_pkg::ADDR_LEVELS);

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[zsm_pkg::ST_SETUP_LSB +: 3] = st_r;
    status_word[zsm_pkg::ST_MON_LSB +: 2]   = mon_r;
    status_word[zsm_pkg::ST_ENABLE_BIT]     = enable_path;
    status_word[zsm_pkg::ST_MODE_BIT]       = mode_dly_r;
    status_word[zsm_pkg::ST_EDIT_LSB +: 4]  = edit_r;
  end

  // apb slave: one wait state, write lands on the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_access;
      pslverr <= apb_access & ~mapped;
      prdata  <= 32'h0000_0000;
      if (apb_access && !pwrite) begin
        if (paddr == zsm_pkg::ADDR_CTRL) begin
          prdata[zsm_pkg::CTRL_LOCK_BIT] <= lock_r;
        end else if (paddr == zsm_pkg::ADDR_STATUS) begin
          prdata <= status_word;
        end else if (paddr == zsm_pkg::ADDR_LEVELS) begin
          prdata[15:0] <= {8'h00, stored_r};
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_r <= zsm_pkg::CTRL_RESET;
    end else if (apb_done_wr && paddr == zsm_pkg::ADDR_CTRL) begin
      lock_r <= pwdata[zsm_pkg::CTRL_LOCK_BIT];
    end
  end

  // active levels; the edited copy only reaches here on save, so a power loss drops it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stored_r.thr <= zsm_pkg::DEF_THR_LEVEL;
      stored_r.dly <= zsm_pkg::DEF_DLY_LEVEL;
      loaded_r     <= 1'b0;
      nv_store     <= 1'b0;
    end else begin
      nv_store <= save;
      if (!loaded_r) begin
        loaded_r     <= 1'b1;
        stored_r.thr <= fix_level(nv_levels.thr, zsm_pkg::DEF_THR_LEVEL);
        stored_r.dly <= fix_level(nv_levels.dly, zsm_pkg::DEF_DLY_LEVEL);
      end else if (save) begin
        if (mode_dly_r) begin
          stored_r.dly <= edit_r;
        end else begin
          stored_r.thr <= edit_r;
        end
      end else if (apb_done_wr && paddr == zsm_pkg::ADDR_LEVELS && st_r == zsm_pkg::SET_RUN) begin
        stored_r.thr <= fix_level(pwdata[zsm_pkg::LEV_THR_LSB +: 4], stored_r.thr);
        stored_r.dly <= fix_level(pwdata[zsm_pkg::LEV_DLY_LSB +: 4], stored_r.dly);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt_r <= 32'h0000_0000;
      idle_cnt_r <= 32'h0000_0000;
    end else begin
      if ((st_r == zsm_pkg::SET_PRESS || st_r == zsm_pkg::SET_EDIT_PRESS) && pressed) begin
        hold_cnt_r <= (hold_cnt_r == 32'hFFFF_FFFF) ? hold_cnt_r : hold_cnt_r + 32'h1;
      end else begin
        hold_cnt_r <= 32'h0000_0000;
      end
      idle_cnt_r <= (st_r == zsm_pkg::SET_EDIT) ? idle_cnt_r + 32'h1 : 32'h0000_0000;
    end
  end

  // setup sequence; it never touches the monitor below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r       <= zsm_pkg::SET_RUN;
      mode_dly_r <= 1'b0;
      edit_r     <= zsm_pkg::DEF_THR_LEVEL;
    end else begin
      unique case (st_r)
        zsm_pkg::SET_RUN: begin
          if (pressed && loaded_r) st_r <= zsm_pkg::SET_PRESS;
        end
        zsm_pkg::SET_PRESS: begin
          if (!pressed) begin
            if (hold_cnt_r >= ENTER_DLY_CYC) begin
              st_r       <= zsm_pkg::SET_EDIT;
              mode_dly_r <= 1'b1;
              edit_r     <= stored_r.dly;
            end else if (hold_cnt_r >= ENTER_THR_CYC) begin
              st_r       <= zsm_pkg::SET_EDIT;
              mode_dly_r <= 1'b0;
              edit_r     <= stored_r.thr;
            end else begin
              st_r <= zsm_pkg::SET_RUN;
            end
          end
        end
        zsm_pkg::SET_EDIT: begin
          if (pressed) begin
            st_r <= zsm_pkg::SET_EDIT_PRESS;
          end else if (idle_cnt_r >= IDLE_CYC - 1) begin
            st_r <= zsm_pkg::SET_RUN;
          end
        end
        zsm_pkg::SET_EDIT_PRESS: begin
          if (save) begin
            st_r <= zsm_pkg::SET_RELEASE;
          end else if (!pressed) begin
            st_r   <= zsm_pkg::SET_EDIT;
            edit_r <= next_level(edit_r);
          end
        end
        zsm_pkg::SET_RELEASE: begin
          if (!pressed) st_r <= zsm_pkg::SET_RUN;
        end
        default: st_r <= zsm_pkg::SET_RUN;
      endcase
    end
  end

  // standstill monitor, always running on the active levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_err_r <= 1'b0;
    end else if (internal_error) begin
      int_err_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_r     <= zsm_pkg::MON_MOTION;
      dly_cnt_r <= 32'h0000_0000;
    end else if (fault_any) begin
      mon_r <= zsm_pkg::MON_FAULT;
    end else begin
      unique case (mon_r)
        zsm_pkg::MON_MOTION: begin
          if (below_on_thr && !above_off_thr) begin
            mon_r     <= zsm_pkg::MON_DELAY;
            dly_cnt_r <= delay_cycles(stored_r.dly) - 32'h1;
          end
        end
        zsm_pkg::MON_DELAY: begin
          if (above_off_thr) begin
            mon_r <= zsm_pkg::MON_MOTION;
          end else if (dly_cnt_r == 32'h0000_0000) begin
            mon_r <= zsm_pkg::MON_STANDSTILL;
          end else begin
            dly_cnt_r <= dly_cnt_r - 32'h1;
          end
        end
        zsm_pkg::MON_STANDSTILL: begin
          if (above_off_thr) mon_r <= zsm_pkg::MON_MOTION;
        end
        zsm_pkg::MON_FAULT: begin
          mon_r <= zsm_pkg::MON_MOTION;
        end
      endcase
    end
  end

  // thresholds for the comparators and the contact outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_thr_mv         <= 10'h000;
      off_thr_mv        <= 10'h000;
      active_levels     <= '0;
      enable_path       <= 1'b0;
      motion_signal_out <= 1'b0;
      fault_signal_out  <= 1'b0;
    end else begin
      on_thr_mv         <= thr_on_mv(stored_r.thr);
      off_thr_mv        <= (stored_r.thr <= zsm_pkg::LEVEL_LAST_LOW) ?
                           zsm_pkg::OFF_THR_LOW_MV : zsm_pkg::OFF_THR_HIGH_MV;
      active_levels     <= stored_r;
      enable_path       <= (mon_r == zsm_pkg::MON_STANDSTILL);
      motion_signal_out <= (mon_r == zsm_pkg::MON_STANDSTILL);
      fault_signal_out  <= (mon_r != zsm_pkg::MON_FAULT);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_cnt_r <= 32'h0000_0000;
      flash_r     <= 1'b0;
    end else if (flash_cnt_r >= FLASH_CYC - 1) begin
      flash_cnt_r <= 32'h0000_0000;
      flash_r     <= ~flash_r;
    end else begin
      flash_cnt_r <= flash_cnt_r + 32'h1;
    end
  end

  // setup display overrides the lamps only; outputs above are untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_indicator <= '0;
      standstill_lamp <= '0;
      level_lamp_low  <= '0;
      level_lamp_high <= '0;
    end else begin
      power_indicator       <= '{red: 1'b0, green: 1'b1};
      standstill_lamp       <= '0;
      level_lamp_low        <= '0;
      level_lamp_high       <= '0;
      if (mon_r == zsm_pkg::MON_FAULT) begin
        power_indicator <= '{red: flash_r, green: 1'b0};
      end
      if (mon_r == zsm_pkg::MON_STANDSTILL) standstill_lamp.green <= 1'b1;
      if (mon_r == zsm_pkg::MON_DELAY) standstill_lamp.green <= flash_r;
      if (st_r == zsm_pkg::SET_PRESS && hold_cnt_r >= ENTER_THR_CYC) begin
        power_indicator <= (hold_cnt_r >= ENTER_DLY_CYC) ? '{1'b0, flash_r} : '{flash_r, 1'b0};
        standstill_lamp <= (hold_cnt_r >= ENTER_DLY_CYC) ? '{1'b0, flash_r} : '{flash_r, 1'b0};
        level_lamp_low  <= (hold_cnt_r >= ENTER_DLY_CYC) ? '{1'b0, flash_r} : '{flash_r, 1'b0};
        level_lamp_high <= (hold_cnt_r >= ENTER_DLY_CYC) ? '{1'b0, flash_r} : '{flash_r, 1'b0};
      end else if (st_r == zsm_pkg::SET_EDIT || st_r == zsm_pkg::SET_EDIT_PRESS) begin
        level_lamp_low  <= '{edit_r[0] & flash_r & ~mode_dly_r, edit_r[0] & flash_r & mode_dly_r};
        level_lamp_high <= '{edit_r[1] & flash_r & ~mode_dly_r, edit_r[1] & flash_r & mode_dly_r};
        standstill_lamp <= '{edit_r[2] & flash_r & ~mode_dly_r, edit_r[2] & flash_r & mode_dly_r};
        power_indicator <= '{edit_r[3] & flash_r & ~mode_dly_r, edit_r[3] & flash_r & mode_dly_r};
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_idle_discards: assert property (st_r == zsm_pkg::SET_EDIT && !pressed &&
    idle_cnt_r >= IDLE_CYC - 1 |=> st_r == zsm_pkg::SET_RUN && $stable(stored_r))
    else $error("idle timeout did not discard edit");
  a_enter_thr: assert property (st_r == zsm_pkg::SET_PRESS && !pressed &&
    hold_cnt_r >= ENTER_THR_CYC && hold_cnt_r < ENTER_DLY_CYC |=>
    st_r == zsm_pkg::SET_EDIT && !mode_dly_r && edit_r == stored_r.thr)
    else $error("threshold setup not entered");
  a_enter_dly: assert property (st_r == zsm_pkg::SET_PRESS && !pressed &&
    hold_cnt_r >= ENTER_DLY_CYC |=> mode_dly_r && edit_r == stored_r.dly)
    else $error("delay setup not entered");
  a_step_level: assert property (st_r == zsm_pkg::SET_EDIT_PRESS && !pressed |=>
    edit_r == next_level($past(edit_r)))
    else $error("short press did not step level");
  a_save_level: assert property (save && !mode_dly_r |=> stored_r.thr == $past(edit_r) &&
    nv_store && st_r == zsm_pkg::SET_RELEASE ##1 !nv_store)
    else $error("save did not store level");
  a_delay_load: assert property (mon_r == zsm_pkg::MON_MOTION && !fault_any &&
    below_on_thr && !above_off_thr |=>
    mon_r == zsm_pkg::MON_DELAY && dly_cnt_r == delay_cycles(stored_r.dly) - 32'h1)
    else $error("delay count not loaded");
  a_motion_opens: assert property (above_off_thr && mon_r != zsm_pkg::MON_MOTION |=>
    mon_r != zsm_pkg::MON_STANDSTILL ##1 !enable_path && !motion_signal_out)
    else $error("movement did not open path");
  a_path_after_delay: assert property ($rose(enable_path) |-> motion_signal_out &&
    $past(mon_r) == zsm_pkg::MON_STANDSTILL && $past(mon_r, 2) != zsm_pkg::MON_MOTION)
    else $error("path closed without delay");
  a_fault_lamp: assert property (mon_r == zsm_pkg::MON_FAULT &&
    st_r == zsm_pkg::SET_RUN |=> !power_indicator.green &&
    power_indicator.red == $past(flash_r) && !fault_signal_out)
    else $error("fault not shown on power lamp");
  a_apb_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  c_save: cover property (save);
  c_idle: cover property (st_r == zsm_pkg::SET_EDIT ##1 st_r == zsm_pkg::SET_RUN);
  c_standstill: cover property (mon_r == zsm_pkg::MON_DELAY ##1 mon_r == zsm_pkg::MON_STANDSTILL);
  c_fault_clear: cover property (mon_r == zsm_pkg::MON_FAULT ##1 mon_r == zsm_pkg::MON_MOTION);

endmodule

// ---- design/zsm_pkg.sv ----
package zsm_pkg;

  // timing, as printed, and derived clock counts at 10 MHz
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned T_ENTER_THR_MS  = 3000;
  localparam int unsigned T_ENTER_DLY_MS  = 6000;
  localparam int unsigned T_SAVE_MS       = 2000;
  localparam int unsigned T_IDLE_MS       = 20000;
  localparam int unsigned T_HALF_SEC_MS   = 500;
  localparam int unsigned T_FLASH_MS      = 250;
  localparam int unsigned CYC_ENTER_THR   = T_ENTER_THR_MS * CYC_PER_MS;
  localparam int unsigned CYC_ENTER_DLY   = T_ENTER_DLY_MS * CYC_PER_MS;
  localparam int unsigned CYC_SAVE        = T_SAVE_MS * CYC_PER_MS;
  localparam int unsigned CYC_IDLE        = T_IDLE_MS * CYC_PER_MS;
  localparam int unsigned CYC_HALF_SEC    = T_HALF_SEC_MS * CYC_PER_MS;
  localparam int unsigned CYC_FLASH       = T_FLASH_MS * CYC_PER_MS;

  // parameter levels
  localparam logic [3:0] LEVEL_MIN        = 4'h1;
  localparam logic [3:0] LEVEL_MAX        = 4'hF;
  localparam logic [3:0] LEVEL_LAST_LOW   = 4'h7;
  localparam logic [3:0] DEF_THR_LEVEL    = 4'h7;
  localparam logic [3:0] DEF_DLY_LEVEL    = 4'h2;
  localparam logic [9:0] OFF_THR_LOW_MV   = 10'h078;
  localparam logic [9:0] OFF_THR_HIGH_MV  = 10'h3E8;

  // register map (byte addresses) and fields
  localparam logic [11:0] ADDR_CTRL       = 12'h000;
  localparam logic [11:0] ADDR_STATUS     = 12'h004;
  localparam logic [11:0] ADDR_LEVELS     = 12'h008;
  localparam int unsigned CTRL_LOCK_BIT   = 0;
  localparam int unsigned LEV_THR_LSB     = 0;
  localparam int unsigned LEV_DLY_LSB     = 4;
  localparam int unsigned ST_SETUP_LSB    = 0;
  localparam int unsigned ST_MON_LSB      = 4;
  localparam int unsigned ST_ENABLE_BIT   = 6;
  localparam int unsigned ST_MODE_BIT     = 7;
  localparam int unsigned ST_EDIT_LSB     = 8;
  localparam logic        CTRL_RESET      = 1'b0;

  typedef enum logic [2:0] {
    SET_RUN        = 3'b000,
    SET_PRESS      = 3'b001,
    SET_EDIT       = 3'b010,
    SET_EDIT_PRESS = 3'b011,
    SET_RELEASE    = 3'b100
  } setup_e;

  typedef enum logic [1:0] {
    MON_MOTION     = 2'b00,
    MON_DELAY      = 2'b01,
    MON_STANDSTILL = 2'b10,
    MON_FAULT      = 2'b11
  } mon_e;

  typedef struct packed {
    logic red;
    logic green;
  } lamp_s;

  typedef struct packed {
    logic [3:0] dly;
    logic [3:0] thr;
  } levels_s;

endpackage

// ---- tb/button_operator.sv ----
`timescale 1ns/1ps
module button_operator (
  input  wire logic clk,
  output logic      pressed
);
  initial pressed = 1'b0;
  // a finger never presses for a single cycle, so callers keep counts well above one
  task automatic hold(input int cycles);
    @(posedge clk);
    pressed <= 1'b1;
    repeat (cycles) @(posedge clk);
    pressed <= 1'b0;
  endtask
  task automatic rest(input int cycles);
    repeat (cycles) @(posedge clk);
  endtask
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  localparam int          HS    = 5;
  localparam logic [11:0] ctl_a = zsm_pkg::ADDR_CTRL;
  localparam logic [11:0] st_a  = zsm_pkg::ADDR_STATUS;
  localparam logic [11:0] lev_a = zsm_pkg::ADDR_LEVELS;
  logic             pclk;
  logic             presetn;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [11:0]      paddr;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic             set_button;
  logic             below_on_thr;
  logic             above_off_thr;
  logic             open_circuit;
  logic             internal_error;
  zsm_pkg::levels_s nv_levels;
  zsm_pkg::levels_s active_levels;
  logic             nv_store;
  logic [9:0]       on_thr_mv;
  logic [9:0]       off_thr_mv;
  logic             enable_path;
  logic             motion_signal_out;
  logic             fault_signal_out;
  zsm_pkg::lamp_s   power_indicator;
  zsm_pkg::lamp_s   standstill_lamp;
  zsm_pkg::lamp_s   level_lamp_low;
  zsm_pkg::lamp_s   level_lamp_high;
  int               failures;
  int               checks_done;
  int               cycles = 0;
  int               stores = 0;
  int               n;
  logic [31:0]      rd;
  logic             err;
  logic [3:0]       seen;
  logic [3:0]       red_v;
  logic [3:0]       grn_v;
  logic [9:0]       on_mv [15] = '{10'h032, 10'h037, 10'h03C, 10'h041, 10'h046, 10'h04B,
    10'h050, 10'h0C8, 10'h0E6, 10'h0FA, 10'h12C, 10'h15E, 10'h190, 10'h1CC, 10'h1F4};
  int               hsec [15] = '{1, 2, 4, 6, 8, 10, 12, 14, 16, 20, 24, 28, 32, 36, 40};

  assign red_v = {power_indicator.red, standstill_lamp.red, level_lamp_high.red,
                  level_lamp_low.red};
  assign grn_v = {power_indicator.green, standstill_lamp.green, level_lamp_high.green,
                  level_lamp_low.green};

  zsm_param_setup #(.ENTER_THR_CYC(30), .ENTER_DLY_CYC(60), .SAVE_CYC(20), .IDLE_CYC(200),
    .HALF_SEC_CYC(HS), .FLASH_CYC(2)) zsm_param_setup_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .set_button, .below_on_thr, .above_off_thr, .open_circuit, .internal_error,
    .nv_levels, .active_levels, .nv_store, .on_thr_mv, .off_thr_mv, .enable_path,
    .motion_signal_out, .fault_signal_out, .power_indicator, .standstill_lamp,
    .level_lamp_low, .level_lamp_high);

  button_operator button_operator_inst (.clk(pclk), .pressed(set_button));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic stop_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // generous ceiling; the level sweeps dominate the run
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    stores <= stores + int'(nv_store === 1'b1);
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic lamps(input logic red);
    seen = 4'h0;
    repeat (12) begin
      @(posedge pclk);
      seen |= red ? red_v : grn_v;
    end
  endtask

  // motion, then run-down; counts cycles until the path closes
  task automatic settle(input int hs, input logic lp);
    int   tg;
    logic last;
    tg = 0;
    n = 0;
    last = 1'b0;
    below_on_thr <= 1'b0;
    above_off_thr <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(enable_path, 1'b0);
    chk(motion_signal_out, 1'b0);
    if (lp)
      chk(standstill_lamp, 2'b00);
    above_off_thr <= 1'b0;
    below_on_thr <= 1'b1;
    while (enable_path !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
      tg += int'(standstill_lamp.green !== last);
      last = standstill_lamp.green;
    end
    chk(n >= hs * HS && n <= hs * HS + 3, 1'b1);
    if (lp && hs > 1)
      chk(tg > 2, 1'b1);
    @(posedge pclk);
    chk(motion_signal_out, 1'b1);
    if (lp)
      chk(standstill_lamp, 2'b01);
  endtask

  initial begin
    failures = 0;
    checks_done = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    below_on_thr = 1'b0;
    above_off_thr = 1'b1;
    open_circuit = 1'b0;
    internal_error = 1'b0;
    nv_levels = 8'h00;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, lev_a, 32'h0);
    chk(rd[7:0], 8'h27);
    chk(on_thr_mv, 10'h050);
    chk(power_indicator, 2'b01);
    apb(1'b0, 12'h00C, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    settle(2, 1'b1);
    for (int i = 1; i <= 15; i++) begin
      apb(1'b1, lev_a, {24'h0, 4'h2, i[3:0]});
      repeat (2) @(posedge pclk);
      chk(on_thr_mv, on_mv[i-1]);
      chk(off_thr_mv, i <= 7 ? 10'h078 : 10'h3E8);
    end
    for (int i = 1; i <= 15; i++) begin
      apb(1'b1, lev_a, {24'h0, i[3:0], 4'h7});
      settle(hsec[i-1], 1'b1);
    end
    apb(1'b1, lev_a, 32'h27);
    // locked button must be ignored
    apb(1'b1, ctl_a, 32'h1);
    apb(1'b0, ctl_a, 32'h0);
    chk(rd[0], 1'b1);
    button_operator_inst.hold(35);
    apb(1'b0, st_a, 32'h0);
    chk(rd[2:0], 3'h0);
    apb(1'b1, ctl_a, 32'h0);
    fork
      button_operator_inst.hold(45);
      begin
        repeat (34) @(posedge pclk);
        lamps(1'b1);
      end
    join
    chk(seen, 4'hF);
    // the entry flash stays on the lamps for two edges after release
    button_operator_inst.rest(2);
    lamps(1'b1);
    chk(seen, 4'h7);
    apb(1'b0, st_a, 32'h0);
    chk({rd[11:7], rd[2:0]}, 8'h72);
    button_operator_inst.hold(5);
    button_operator_inst.rest(3);
    apb(1'b0, st_a, 32'h0);
    chk({rd[11:7], rd[2:0]}, 8'h82);
    button_operator_inst.hold(25);
    button_operator_inst.rest(3);
    apb(1'b0, st_a, 32'h0);
    chk(rd[2:0], 3'h0);
    chk(active_levels, 8'h28);
    chk(on_thr_mv, 10'h0C8);
    chk(stores, 1);
    fork
      button_operator_inst.hold(78);
      begin
        repeat (64) @(posedge pclk);
        lamps(1'b0);
      end
    join
    chk(seen, 4'hF);
    button_operator_inst.rest(2);
    lamps(1'b0);
    chk(seen, 4'h2);
    apb(1'b0, st_a, 32'h0);
    chk({rd[11:7], rd[2:0]}, 8'h2A);
    button_operator_inst.hold(5);
    button_operator_inst.rest(3);
    apb(1'b0, st_a, 32'h0);
    chk({rd[11:7], rd[2:0]}, 8'h3A);
    settle(2, 1'b0);
    chk(enable_path, 1'b1);
    button_operator_inst.rest(210);
    apb(1'b0, st_a, 32'h0);
    chk(rd[2:0], 3'h0);
    chk(active_levels, 8'h28);
    chk(stores, 1);
    open_circuit <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(fault_signal_out, 1'b0);
    chk(enable_path, 1'b0);
    lamps(1'b1);
    chk(seen[3], 1'b1);
    open_circuit <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(fault_signal_out, 1'b1);
    settle(2, 1'b1);
    internal_error <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(fault_signal_out, 1'b0);
    // power loss in the middle of an edit: the stored copy comes back
    button_operator_inst.hold(35);
    button_operator_inst.hold(5);
    apb(1'b0, st_a, 32'h0);
    chk({rd[11:7], rd[2:0]}, 8'h92);
    presetn <= 1'b0;
    internal_error <= 1'b0;
    nv_levels <= 8'h28;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(active_levels, 8'h28);
    chk(fault_signal_out, 1'b1);
    apb(1'b0, st_a, 32'h0);
    chk(rd[2:0], 3'h0);
    stop_test();
  end
endmodule
